//--- pkg/pcr_pkg.sv
package pcr_pkg;

  // ****************************************************************
  // register offsets (byte addresses in configuration space)
  // ****************************************************************
  localparam logic [7:0] PM_CAP_OFS  = 8'hDC;
  localparam logic [7:0] PM_CSR_OFS  = 8'hE0;
  localparam logic [7:0] HS_CAP_OFS  = 8'hE4;
  localparam logic [7:0] PD_CAP_OFS  = 8'hE8;
  localparam logic [7:0] PD_WORD_OFS = 8'hEC;

  // ****************************************************************
  // capability header values
  // ****************************************************************
  localparam logic [7:0] PM_CAPABILITY_IDENTIFIER   = 8'h01;
  localparam logic [7:0] PM_NEXT     = 8'hE4;
  localparam logic [7:0] HS_CAPABILITY_IDENTIFIER   = 8'h06;
  localparam logic [7:0] HS_NEXT_PD  = 8'hE8;
  localparam logic [7:0] LIST_END    = 8'h00;
  localparam logic [7:0] PD_CAPABILITY_IDENTIFIER   = 8'h03;
  localparam logic [7:0] BSE_VALUE   = 8'h00;

  // ****************************************************************
  // field layout and reset values
  // ****************************************************************
  localparam logic [2:0] POWER_MGMT_VERSION_RST  = 3'h1;
  localparam logic [4:0] SUP_RST     = 5'h00;
  localparam logic [4:0] SUP_KEEP    = 5'h09;   // only bits 3 and 0 may be set
  localparam logic [1:0] PS_D0       = 2'h0;
  localparam logic [1:0] PS_D3HOT    = 2'h3;
  localparam int         PMCS_ST_BIT = 15;
  localparam int         PMCS_EN_BIT = 8;
  localparam int         HS_INS_BIT  = 23;
  localparam int         HS_EXT_BIT  = 22;
  localparam int         HS_LED_BIT  = 19;
  localparam int         HS_EIM_BIT  = 17;
  localparam int         PD_FLAG_BIT = 31;

  typedef enum logic [1:0] {PD_IDLE, PD_BUSY} pcr_pd_state_type;

endpackage : pcr_pkg

//--- hw/pcr_w1c_flag.sv
`timescale 1ns/1ns
module pcr_w1c_flag
  import pcr_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // event and clear
  input  wire logic setEvt,
  input  wire logic clrReq,
  // state
  output logic      flag_r
);

  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flag_r <= 1'b0;
    end else if (setEvt) begin
      flag_r <= 1'b1;
    end else if (clrReq) begin
      flag_r <= 1'b0;
    end
  end

endmodule : pcr_w1c_flag

//--- hw/pcr_pd_access.sv
`timescale 1ns/1ns
module pcr_pd_access
  import pcr_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // start from a flag write
  input  wire logic        startReq,
  input  wire logic        startWrite,
  // storage engine handshake
  output logic             engReq_r,
  output logic             engWrite_r,
  input  wire logic        engDone,
  input  wire logic [31:0] engRdata,
  // completion
  output logic             doneEvt_r,
  output logic             doneWrite_r,
  output logic [31:0]      doneData_r
);

  pcr_pd_state_type state_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r     <= PD_IDLE;
      engReq_r    <= 1'b0;
      engWrite_r  <= 1'b0;
      doneEvt_r   <= 1'b0;
      doneWrite_r <= 1'b0;
      doneData_r  <= 32'h0000_0000;
    end else begin
      doneEvt_r <= 1'b0;
      case (state_r)
        PD_IDLE: begin
          if (startReq) begin
            engReq_r   <= 1'b1;
            engWrite_r <= startWrite;
            state_r    <= PD_BUSY;
          end
        end
        PD_BUSY: begin
          // a new flag write while busy is ignored until the engine answers
          if (engDone) begin
            engReq_r    <= 1'b0;
            doneEvt_r   <= 1'b1;
            doneWrite_r <= engWrite_r;
            doneData_r  <= engRdata;
            state_r     <= PD_IDLE;
          end
        end
        default: state_r <= PD_IDLE;
      endcase
    end
  end

endmodule : pcr_pd_access

//--- hw/pcr_cap_regs.sv
`timescale 1ns/1ns
// Notes on behaviour
// - event support bits: bit0 D0, bit3 D3hot
// - support bits 4, 2, 1 always zero
// - D2 and D1 support read zero
// - auxiliary power source reads zero
// - event clock equals OR of support bits
// - power management version resets to 001
// - PM header id 0x01, next 0xE4
// - event status sticky, write 1 clears
// - event enable gates event signal
// - unimplemented power state write is ignored
// - only D0 and D3hot states held
// - bridge support byte reads 0x00
// - insertion set after load, disable clear
// - extraction set on switch high, reset off
// - enumeration mask: 0 allows, 1 suppresses
// - hot swap header id 0x06
// - hot swap next 0xE8 or 0x00
// - flag write starts store or load
// - product data header id 0x03, next 0x00
module pcr_cap_regs
  import pcr_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // configuration access from the host
  input  wire logic        cfgWrite,
  input  wire logic        cfgRead,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWdata,
  output logic [31:0]      cfgRdata_r,
  // local-side preload of host read-only fields, reloaded on every locLoad pulse
  input  wire logic        locLoad,
  input  wire logic [4:0]  locEventSupport,
  input  wire logic [2:0]  locVersion,
  input  wire logic        locDsi,
  // device status inputs
  input  wire logic        eventRaise,
  input  wire logic        loadDone,
  input  wire logic        hostSideDisable,
  input  wire logic        ejectorSwitchInput,
  input  wire logic        productDataEnable,
  // storage engine for product data
  output logic             engReq_r,
  output logic             engWrite_r,
  output logic [7:0]       engAddr_r,
  output logic [31:0]      engWdata_r,
  input  wire logic        engDone,
  input  wire logic [31:0] engRdata,
  // outputs to pins and the rest of the bridge
  output logic             powerEvent_r,
  output logic             enumAssert_r,
  output logic             indicatorLedOn_r,
  output logic [1:0]       powerState_r
);

  // ****************************************************************
  // decode
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  // the capabilities word has no host write path: every field there is read-only
  logic wrPmcs;
  logic wrHs;
  logic wrPd;
  logic wrPdw;
  assign wrPmcs = cfgWrite && hit(cfgAddr, PM_CSR_OFS);
  assign wrHs   = cfgWrite && hit(cfgAddr, HS_CAP_OFS);
  assign wrPd   = cfgWrite && hit(cfgAddr, PD_CAP_OFS);
  assign wrPdw  = cfgWrite && hit(cfgAddr, PD_WORD_OFS);

  // per-lane write strobes; every writable field except the product data word sits in a single byte lane
  logic csrLane0;
  logic csrLane1;
  logic hsLane2;
  logic pdLane2;
  logic pdLane3;
  assign csrLane0 = wrPmcs && cfgByteEn[0];
  assign csrLane1 = wrPmcs && cfgByteEn[1];
  assign hsLane2  = wrHs && cfgByteEn[2];
  assign pdLane2  = wrPd && cfgByteEn[2];
  assign pdLane3  = wrPd && cfgByteEn[3];

  // ****************************************************************
  // power management capabilities
  // ****************************************************************
  logic [4:0] eventStateSupport_r;
  logic [2:0] powerMgmtVersion_r;
  logic       devInit_r;
  logic       eventClockRequired;

  // these fields are host read-only; only the local side preloads them
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      eventStateSupport_r <= SUP_RST;
      powerMgmtVersion_r  <= POWER_MGMT_VERSION_RST;
      devInit_r           <= 1'b0;
    end else if (locLoad) begin
      eventStateSupport_r <= locEventSupport & SUP_KEEP;
      powerMgmtVersion_r  <= locVersion;
      devInit_r           <= locDsi;
    end
  end

  assign eventClockRequired = |eventStateSupport_r;

  // ****************************************************************
  // power management control and status
  // ****************************************************************
  logic eventEnable_r;
  logic eventStatus_r;
  logic stClr;
  logic stNxt;
  logic enNxt;
  logic psLegal;

  // other codes complete on the bus but leave the state alone
  assign psLegal = (cfgWdata[1:0] == PS_D0) || (cfgWdata[1:0] == PS_D3HOT);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      eventEnable_r <= 1'b0;
      powerState_r  <= PS_D0;
    end else begin
      if (csrLane1) begin
        eventEnable_r <= cfgWdata[PMCS_EN_BIT];
      end
      if (csrLane0 && psLegal) begin
        powerState_r <= cfgWdata[1:0];
      end
    end
  end

  assign stClr = csrLane1 && cfgWdata[PMCS_ST_BIT];

  // next-state values so the pin follows the flag with no extra lag
  assign stNxt = eventRaise || (eventStatus_r && !stClr);
  assign enNxt = csrLane1 ? cfgWdata[PMCS_EN_BIT] : eventEnable_r;

  pcr_w1c_flag u_evtSt (
    .sys_clk (sys_clk),
    .srst    (srst),
    .setEvt  (eventRaise),
    .clrReq  (stClr),
    .flag_r  (eventStatus_r)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      powerEvent_r <= 1'b0;
    end else begin
      powerEvent_r <= stNxt && enNxt;
    end
  end

  // ****************************************************************
  // hot swap
  // ****************************************************************
  logic insertionStatus_r;
  logic extractionStatus_r;
  logic enumInterruptMask_r;
  logic insClr;
  logic extClr;
  logic insSet;
  logic extSet;
  logic loadReady;
  logic loadReadyPrev_r;
  logic enumPendNxt;
  logic enumMaskNxt;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      indicatorLedOn_r    <= 1'b0;
      enumInterruptMask_r <= 1'b0;
    end else if (hsLane2) begin
      indicatorLedOn_r    <= cfgWdata[HS_LED_BIT];
      enumInterruptMask_r <= cfgWdata[HS_EIM_BIT];
    end
  end

  // insertion fires each time load completion and a clear disable begin to meet,
  // so a disable lifted after the load still reports the card; the loader must
  // drop loadDone across a bus reset or the card is reported again
  assign loadReady = loadDone && !hostSideDisable;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      loadReadyPrev_r <= 1'b0;
    end else begin
      loadReadyPrev_r <= loadReady;
    end
  end

  assign insSet = loadReady && !loadReadyPrev_r;
  assign extSet = ejectorSwitchInput && !srst;
  assign insClr = hsLane2 && cfgWdata[HS_INS_BIT];
  assign extClr = hsLane2 && cfgWdata[HS_EXT_BIT];

  // a status bit cleared by this very write no longer asks for attention
  assign enumPendNxt = insSet || extSet || (insertionStatus_r && !insClr)
                       || (extractionStatus_r && !extClr);
  assign enumMaskNxt = hsLane2 ? cfgWdata[HS_EIM_BIT] : enumInterruptMask_r;

  pcr_w1c_flag u_ins (
    .sys_clk (sys_clk),
    .srst    (srst),
    .setEvt  (insSet),
    .clrReq  (insClr),
    .flag_r  (insertionStatus_r)
  );

  pcr_w1c_flag u_ext (
    .sys_clk (sys_clk),
    .srst    (srst),
    .setEvt  (extSet),
    .clrReq  (extClr),
    .flag_r  (extractionStatus_r)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      enumAssert_r <= 1'b0;
    end else begin
      enumAssert_r <= enumPendNxt && !enumMaskNxt;
    end
  end

  // ****************************************************************
  // product data access
  // ****************************************************************
  logic       productDataFlag_r;
  logic [31:0] productDataWord_r;
  logic       pdDone;
  logic       pdDoneWrite;
  logic [31:0] pdDoneData;
  logic       pdStart;

  assign pdStart = pdLane3;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      engAddr_r <= 8'h00;
    end else if (pdLane2) begin
      engAddr_r <= {cfgWdata[23:18], 2'b00};
    end
  end

  // engine completion owns the flag over a same-cycle host write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      productDataFlag_r <= 1'b0;
    end else if (pdDone) begin
      productDataFlag_r <= !pdDoneWrite;
    end else if (pdStart) begin
      productDataFlag_r <= cfgWdata[PD_FLAG_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      productDataWord_r <= 32'h0000_0000;
    end else if (pdDone && !pdDoneWrite) begin
      productDataWord_r <= pdDoneData;
    end else if (wrPdw) begin
      for (int b = 0; b < 4; b++) begin
        if (cfgByteEn[b]) begin
          productDataWord_r[b*8 +: 8] <= cfgWdata[b*8 +: 8];
        end
      end
    end
  end

  assign engWdata_r = productDataWord_r;

  pcr_pd_access u_pd (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .startReq    (pdStart),
    .startWrite  (cfgWdata[PD_FLAG_BIT]),
    .engReq_r    (engReq_r),
    .engWrite_r  (engWrite_r),
    .engDone     (engDone),
    .engRdata    (engRdata),
    .doneEvt_r   (pdDone),
    .doneWrite_r (pdDoneWrite),
    .doneData_r  (pdDoneData)
  );

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [31:0] rdNxt;

  always_comb begin
    rdNxt = 32'h0000_0000;
    case (cfgAddr[7:2])
      PM_CAP_OFS[7:2]: begin
        rdNxt[31:27] = eventStateSupport_r;
        rdNxt[26]    = 1'b0;
        rdNxt[25]    = 1'b0;
        rdNxt[21]    = devInit_r;
        rdNxt[20]    = 1'b0;
        rdNxt[19]    = eventClockRequired;
        rdNxt[18:16] = powerMgmtVersion_r;
        rdNxt[15:0]  = {PM_NEXT, PM_CAPABILITY_IDENTIFIER};
      end
      PM_CSR_OFS[7:2]: begin
        rdNxt[23:16]       = BSE_VALUE;
        rdNxt[PMCS_ST_BIT] = eventStatus_r;
        rdNxt[PMCS_EN_BIT] = eventEnable_r;
        rdNxt[1:0]         = powerState_r;
      end
      HS_CAP_OFS[7:2]: begin
        rdNxt[HS_INS_BIT] = insertionStatus_r;
        rdNxt[HS_EXT_BIT] = extractionStatus_r;
        rdNxt[HS_LED_BIT] = indicatorLedOn_r;
        rdNxt[HS_EIM_BIT] = enumInterruptMask_r;
        rdNxt[15:8]       = productDataEnable ? HS_NEXT_PD : LIST_END;
        rdNxt[7:0]        = HS_CAPABILITY_IDENTIFIER;
      end
      PD_CAP_OFS[7:2]: begin
        rdNxt[PD_FLAG_BIT] = productDataFlag_r;
        rdNxt[23:16]       = engAddr_r;
        rdNxt[15:0]        = {LIST_END, PD_CAPABILITY_IDENTIFIER};
      end
      PD_WORD_OFS[7:2]: rdNxt = productDataWord_r;
      default:          rdNxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfgRdata_r <= 32'h0000_0000;
    end else if (cfgRead) begin
      cfgRdata_r <= rdNxt;
    end
  end

endmodule : pcr_cap_regs

//--- dv/pcr_cap_regs_asserts.sv
`timescale 1ns/1ns
module pcr_cap_regs_asserts
  import pcr_pkg::*;
(
  // host access
  input logic        sys_clk, srst, cfgWrite, cfgRead,
  input logic [7:0]  cfgAddr,
  input logic [3:0]  cfgByteEn,
  input logic [31:0] cfgWdata, cfgRdata_r,
  // status and outputs
  input logic        eventRaise, productDataEnable, engReq_r, engWrite_r, engDone,
  input logic        powerEvent_r, enumAssert_r, indicatorLedOn_r,
  input logic [1:0]  powerState_r
);
  // ********
  // port checks
  // ********
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic pm, cs, hs, pd;
  assign pm = cfgAddr[7:2] == PM_CAP_OFS[7:2];
  assign cs = cfgAddr[7:2] == PM_CSR_OFS[7:2];
  assign hs = cfgAddr[7:2] == HS_CAP_OFS[7:2];
  assign pd = cfgAddr[7:2] == PD_CAP_OFS[7:2];
  rst_clear_a:
  assert property (disable iff (1'b0) srst |=> !powerEvent_r && !enumAssert_r && !engReq_r
    && !indicatorLedOn_r && powerState_r == PS_D0) else $error("outputs kept after reset");
  pm_caps_a:
  assert property (cfgRead && pm |=> cfgRdata_r[15:0] == {PM_NEXT, PM_CAPABILITY_IDENTIFIER}
    && {cfgRdata_r[31], cfgRdata_r[29:28], cfgRdata_r[26:25], cfgRdata_r[20]} == 6'h00
    && cfgRdata_r[19] == |cfgRdata_r[31:27]) else $error("power caps word wrong");
  csr_ro_a:
  assert property (cfgRead && cs |=> cfgRdata_r[23:16] == BSE_VALUE
    && cfgRdata_r[1:0] == $past(powerState_r)) else $error("control word wrong");
  ps_keep_a:
  assert property (cfgWrite && cs && cfgByteEn[0] && cfgWdata[1:0] inside {2'h1, 2'h2}
    |=> $stable(powerState_r)) else $error("bad power state taken");
  hs_head_a:
  assert property (cfgRead && hs |=> cfgRdata_r[15:0] ==
    {($past(productDataEnable) ? HS_NEXT_PD : LIST_END), HS_CAPABILITY_IDENTIFIER})
    else $error("hot swap header wrong");
  pd_head_a:
  assert property (cfgRead && pd |=> cfgRdata_r[15:0] == {LIST_END, PD_CAPABILITY_IDENTIFIER})
    else $error("product data header wrong");
  eng_start_a:
  assert property (cfgWrite && pd && cfgByteEn[3] && !engReq_r |=> engReq_r
    && engWrite_r == $past(cfgWdata[31])) else $error("flag write did not start");
  evt_off_a:
  assert property (cfgWrite && cs && cfgByteEn[1] && !eventRaise
    && (cfgWdata[15] || !cfgWdata[8]) |=> !powerEvent_r) else $error("event stayed on");
  cover property (engDone && engWrite_r);
  cover property (engDone && !engWrite_r);
  cover property ($rose(powerEvent_r));
  cover property ($rose(enumAssert_r));
endmodule : pcr_cap_regs_asserts

//--- dv/pcr_store_model.sv
`timescale 1ns/1ns
module pcr_store_model (
  // request and answer
  input  logic        sys_clk, srst, engReq_r, engWrite_r, slowMode,
  input  logic [7:0]  engAddr_r,
  input  logic [31:0] engWdata_r,
  output logic        engDone,
  output logic [31:0] engRdata
);
  // ********
  // storage behind the product data engine
  // ********
  logic [31:0] mem [64];
  logic [31:0] hold = 32'h5A5A5A5A;
  int          cnt;
  // idle data lines show the inverse of the last word, never a stale copy
  assign engRdata = engDone ? hold : ~hold;
  always @(posedge sys_clk) begin
    if (srst || !engReq_r) begin
      cnt <= 0;
      engDone <= 1'b0;
    end else if (cnt == (slowMode ? 7 : 1)) begin
      engDone <= 1'b1;
      hold <= mem[engAddr_r[7:2]];
      if (engWrite_r) mem[engAddr_r[7:2]] <= engWdata_r;
      cnt <= 8;
    end else begin
      engDone <= 1'b0;
      // parks at 8 so a request still high after the answer is not served twice
      cnt <= (cnt == 8) ? 8 : cnt + 1;
    end
  end
endmodule : pcr_store_model

//--- dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import pcr_pkg::*;
  // ********
  // design, storage model and stimulus
  // ********
  logic        sys_clk, srst, cfgWrite, cfgRead, locLoad, locDsi, eventRaise, loadDone;
  logic        hostSideDisable, ejectorSwitchInput, productDataEnable, slowMode, engDone;
  logic        engReq_r, engWrite_r, powerEvent_r, enumAssert_r, indicatorLedOn_r;
  logic [7:0]  cfgAddr, engAddr_r, pdAddr;
  logic [3:0]  cfgByteEn;
  logic [4:0]  locEventSupport;
  logic [2:0]  locVersion;
  logic [1:0]  powerState_r, psExp;
  logic [31:0] cfgWdata, cfgRdata_r, engWdata_r, engRdata, rv, pdData;
  logic [1:0]  psCode [5] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h2};
  int          err_total, samples_checked;
  pcr_cap_regs    pcr_cap_regs_inst (.*);
  pcr_store_model pcr_store_model_inst (.*);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] capExp(logic [4:0] s, logic [2:0] v, logic d);
    return {s & 5'h09, 5'h00, d, 1'b0, |(s & 5'h09), v, 8'hE4, 8'h01};
  endfunction : capExp
  task automatic check(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : pulse
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfgAddr = a;
    cfgByteEn = be;
    cfgWdata = d;
    pulse(cfgWrite);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    cfgAddr = a;
    cfgRead = 1'b1;
    tick(1);
    cfgRead = 1'b0;
    rv = cfgRdata_r;
    tick(1);
  endtask : rd
  task automatic waitFlag(input logic f, input logic [7:0] a);
    rd(PD_CAP_OFS);
    for (int n = 0; n < 30 && rv[31] !== f; n++) rd(PD_CAP_OFS);
    check("pdFlag", rv, {f, 7'h00, a, 16'h0003});
  endtask : waitFlag
  task automatic chkReset;
    rd(PM_CAP_OFS);
    check("pmCaps", rv, capExp(5'h00, 3'h1, 1'b0));
    rd(PM_CSR_OFS);
    check("pmCsr", rv, 32'h00000000);
    rd(HS_CAP_OFS);
    check("hsCap", rv, 32'h00000006);
    rd(PD_CAP_OFS);
    check("pdCap", rv, 32'h00000003);
    rd(8'hF0);
    check("unmapped", rv, 32'h00000000);
    check("pins", {powerEvent_r, enumAssert_r, indicatorLedOn_r, powerState_r}, 0);
  endtask : chkReset
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial begin
    {cfgWrite, cfgRead, locLoad, locDsi, eventRaise, loadDone, slowMode} = '0;
    {hostSideDisable, ejectorSwitchInput, productDataEnable} = '0;
    {cfgAddr, cfgByteEn, cfgWdata, locEventSupport, locVersion} = '0;
    err_total = 0;
    samples_checked = 0;
    void'($urandom(20));
    srst = 1'b1;
    tick(4);
    srst = 1'b0;
    chkReset();
    productDataEnable = 1'b1;
    rd(HS_CAP_OFS);
    check("hsNext", rv, 32'h0000E806);
    // all-clear support first: the event clock bit must then read low
    for (int i = 0; i < 5; i++) begin
      locEventSupport = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
      locVersion = 3'($urandom);
      locDsi = 1'($urandom);
      pulse(locLoad);
      wr(PM_CAP_OFS, 4'hF, 32'hFFFFFFFF);
      rd(PM_CAP_OFS);
      check("pmCaps", rv, capExp(locEventSupport, locVersion, locDsi));
    end
    psExp = PS_D0;
    foreach (psCode[i]) begin
      wr(PM_CSR_OFS, 4'h5, {16'h00FF, 8'h00, 6'($urandom), psCode[i]});
      if (psCode[i] inside {PS_D0, PS_D3HOT}) psExp = psCode[i];
      rd(PM_CSR_OFS);
      check("pmState", rv, {30'h0, psExp});
    end
    wr(PM_CSR_OFS, 4'h2, 32'h00000100);
    pulse(eventRaise);
    check("pmEvent", powerEvent_r, 1'b1);
    wr(PM_CSR_OFS, 4'h2, 32'h00008100);
    check("pmEventClr", powerEvent_r, 1'b0);
    wr(PM_CSR_OFS, 4'h2, 32'h00000000);
    pulse(eventRaise);
    check("pmEventOff", powerEvent_r, 1'b0);
    rd(PM_CSR_OFS);
    check("pmStatus", rv, 32'h00008000);
    // load finished while disabled: nothing reported until the disable lifts
    hostSideDisable = 1'b1;
    loadDone = 1'b1;
    tick(2);
    rd(HS_CAP_OFS);
    check("hsInsHeld", rv, 32'h0000E806);
    check("enumHeld", enumAssert_r, 1'b0);
    hostSideDisable = 1'b0;
    tick(2);
    rd(HS_CAP_OFS);
    check("hsIns", rv, 32'h0080E806);
    check("enumOn", enumAssert_r, 1'b1);
    wr(HS_CAP_OFS, 4'h4, 32'h000A0000);
    check("enumMask", {enumAssert_r, indicatorLedOn_r}, 2'h1);
    wr(HS_CAP_OFS, 4'h4, 32'h008A0000);
    pulse(ejectorSwitchInput);
    rd(HS_CAP_OFS);
    check("hsExt", rv, 32'h004AE806);
    wr(HS_CAP_OFS, 4'h4, 32'h00400000);
    rd(HS_CAP_OFS);
    check("hsClear", rv, 32'h0000E806);
    check("enumOff", enumAssert_r, 1'b0);
    for (int i = 0; i < 2; i++) begin
      slowMode = 1'(i);
      pdAddr = 8'($urandom) & 8'hFC;
      pdData = $urandom;
      wr(PD_WORD_OFS, 4'hF, pdData);
      wr(PD_CAP_OFS, 4'hC, {8'h80, pdAddr | 8'h03, 16'h0000});
      waitFlag(1'b0, pdAddr);
      wr(PD_WORD_OFS, 4'hF, ~pdData);
      wr(PD_CAP_OFS, 4'hC, {8'h00, pdAddr, 16'h0000});
      waitFlag(1'b1, pdAddr);
      rd(PD_WORD_OFS);
      check("pdLoad", rv, pdData);
    end
    wr(PM_CSR_OFS, 4'h3, 32'h00000103);
    wr(HS_CAP_OFS, 4'h4, 32'h00080000);
    // the serial load reruns after a bus reset, so its done level drops with it
    srst = 1'b1;
    loadDone = 1'b0;
    tick(2);
    srst = 1'b0;
    productDataEnable = 1'b0;
    chkReset();
    close_out();
  end
  initial begin
    #100000;
    err_total++;
    close_out();
  end
endmodule : tb_top
bind pcr_cap_regs pcr_cap_regs_asserts pcr_cap_regs_asserts_inst (.*);
